// ===== src/dsp_core_cfg.svh
// constants for the multiply and scale datapath
`ifndef DSP_CORE_CFG_SVH
`define DSP_CORE_CFG_SVH
`define DATA_W 16
`define PROD_W 32
`define IN_SHIFT_MAX 5'h10
`define PROD_SHIFT_LEFT_A 1
`define PROD_SHIFT_LEFT_B 4
`define PROD_SHIFT_RIGHT 6
`define STACK_DEPTH 8
`define TRAP_COUNT 32
`define TRAP_BASE 16'h0000
`define TRAP_STRIDE_SHIFT 1
`define ADDR_RST 16'h0000
`define ACC_RST 32'h0000_0000
`define PROD_RST 32'h0000_0000
`define OPND_RST 16'h0000
`define CARRY_RST 1'h1
`endif

// ===== src/dsp_core_pkg.sv
// types for the multiply and scale datapath
package dsp_core_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_LOAD_ACC, OP_ADD, OP_SUB,
    OP_LOAD_ACC_DYN, OP_ADD_DYN, OP_SUB_DYN,
    OP_LOAD_OPND, OP_MULTIPLY, OP_LOAD_PROD_ACC, OP_ADD_PROD, OP_SUB_PROD,
    OP_BIT_DYN, OP_STORE_ACC, OP_STORE_PROD,
    OP_SHIFT_ACC, OP_ROTATE_ACC,
    OP_BRANCH, OP_CALL, OP_RETURN, OP_TRAP, OP_PUSH, OP_POP, OP_BLOCK
  } op_t;
  typedef enum logic [1:0] {PM_NONE, PM_LEFT_A, PM_LEFT_B, PM_RIGHT} pm_t;
  typedef enum logic [2:0] {COND_ALWAYS, COND_EQ, COND_NE, COND_LT, COND_GT, COND_TC, COND_C} cond_t;
endpackage

// ===== src/dsp_core_multiply_scale_datapath.sv
// multiply, scale and program-address datapath of the signal-processor core
`timescale 1ns/1ps
`include "dsp_core_cfg.svh"

module dsp_core_multiply_scale_datapath #(
  parameter int STACK_DEPTH = `STACK_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // decoded instruction
  input wire logic op_valid,
  input wire dsp_core_pkg::op_t op,
  input wire logic signed_mode,
  input wire logic sign_ext,
  input wire logic [4:0] shift_amt,
  input wire dsp_core_pkg::pm_t pm_mode,
  input wire logic [2:0] out_shift,
  input wire logic out_high,
  input wire dsp_core_pkg::cond_t cond,
  input wire logic [15:0] target,
  input wire logic [4:0] trap_num,
  input wire logic [15:0] block_len,
  // data buses
  input wire logic [15:0] data_in,
  output logic [15:0] data_write_bus,
  output logic data_write_valid,
  // program memory
  input wire logic mem_ready,
  output logic [15:0] program_address_bus,
  // state
  output logic [31:0] accumulator,
  output logic [31:0] product_register,
  output logic [15:0] multiplier_operand_register,
  output logic test_flag,
  output logic carry,
  output logic [3:0] stack_depth,
  output logic stack_error,
  output logic block_active
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic is_dyn(dsp_core_pkg::op_t o);
    return o == dsp_core_pkg::OP_LOAD_ACC_DYN || o == dsp_core_pkg::OP_ADD_DYN || o == dsp_core_pkg::OP_SUB_DYN;
  endfunction

  function automatic logic is_push(dsp_core_pkg::op_t o);
    return o == dsp_core_pkg::OP_CALL || o == dsp_core_pkg::OP_TRAP || o == dsp_core_pkg::OP_PUSH;
  endfunction

  function automatic logic is_pop(dsp_core_pkg::op_t o);
    return o == dsp_core_pkg::OP_RETURN || o == dsp_core_pkg::OP_POP;
  endfunction

  // ----------------------------------------
  // controller: issue, stall and conditions
  // ----------------------------------------
  // a wait state freezes every stage but the data_write_valid strobe, which drops to 0, so nothing issues twice
  logic take;
  logic cond_true;
  assign take = op_valid && mem_ready;

  always_comb begin
    case (cond)
      dsp_core_pkg::COND_ALWAYS: cond_true = 1'b1;
      dsp_core_pkg::COND_EQ: cond_true = accumulator == 32'h0000_0000;
      dsp_core_pkg::COND_NE: cond_true = accumulator != 32'h0000_0000;
      dsp_core_pkg::COND_LT: cond_true = accumulator[31];
      dsp_core_pkg::COND_GT: cond_true = !accumulator[31] && accumulator != 32'h0000_0000;
      dsp_core_pkg::COND_TC: cond_true = test_flag;
      dsp_core_pkg::COND_C: cond_true = carry;
      default: cond_true = 1'b0;
    endcase
  end

  // ----------------------------------------
  // input scaler
  // ----------------------------------------
  logic [4:0] raw_shift;
  logic [4:0] in_shift;
  logic [31:0] in_ext;
  logic [31:0] in_scaled;
  assign raw_shift = is_dyn(op) ? {1'b0, multiplier_operand_register[3:0]} : shift_amt;
  assign in_shift = raw_shift > `IN_SHIFT_MAX ? `IN_SHIFT_MAX : raw_shift;
  assign in_ext = sign_ext ? {{16{data_in[15]}}, data_in} : {16'h0000, data_in};
  // combinational so a shifted load costs the same cycle as a plain one
  assign in_scaled = in_ext << in_shift;

  // ----------------------------------------
  // multiplier and product scaler
  // ----------------------------------------
  logic [31:0] product;
  logic [31:0] prod_scaled;
  always_comb begin
    if (signed_mode) begin
      product = 32'($signed(multiplier_operand_register) * $signed(data_in));
    end else begin
      product = 32'(multiplier_operand_register * data_in);
    end
  end

  always_comb begin
    case (pm_mode)
      dsp_core_pkg::PM_NONE: prod_scaled = product_register;
      dsp_core_pkg::PM_LEFT_A: prod_scaled = product_register << `PROD_SHIFT_LEFT_A;
      dsp_core_pkg::PM_LEFT_B: prod_scaled = product_register << `PROD_SHIFT_LEFT_B;
      dsp_core_pkg::PM_RIGHT: prod_scaled = 32'($signed(product_register) >>> `PROD_SHIFT_RIGHT);
      default: prod_scaled = product_register;
    endcase
  end

  // ----------------------------------------
  // output scaler
  // ----------------------------------------
  logic [31:0] out_scaled;
  assign out_scaled = accumulator << out_shift;

  // ----------------------------------------
  // operand and product registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      multiplier_operand_register <= `OPND_RST;
    end else if (take && op == dsp_core_pkg::OP_LOAD_OPND) begin
      multiplier_operand_register <= data_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      product_register <= `PROD_RST;
    end else if (take && op == dsp_core_pkg::OP_MULTIPLY) begin
      product_register <= product;
    end
  end

  // ----------------------------------------
  // accumulator and status
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      accumulator <= `ACC_RST;
      carry <= `CARRY_RST;
    end else if (take) begin
      case (op)
        dsp_core_pkg::OP_LOAD_ACC, dsp_core_pkg::OP_LOAD_ACC_DYN: accumulator <= in_scaled;
        dsp_core_pkg::OP_ADD, dsp_core_pkg::OP_ADD_DYN: {carry, accumulator} <= {1'b0, accumulator} + {1'b0, in_scaled};
        dsp_core_pkg::OP_SUB, dsp_core_pkg::OP_SUB_DYN: begin
          accumulator <= accumulator - in_scaled;
          carry <= accumulator >= in_scaled;
        end
        dsp_core_pkg::OP_LOAD_PROD_ACC: accumulator <= prod_scaled;
        dsp_core_pkg::OP_ADD_PROD: {carry, accumulator} <= {1'b0, accumulator} + {1'b0, prod_scaled};
        dsp_core_pkg::OP_SUB_PROD: begin
          accumulator <= accumulator - prod_scaled;
          carry <= accumulator >= prod_scaled;
        end
        dsp_core_pkg::OP_SHIFT_ACC: {carry, accumulator} <= {accumulator, 1'b0};
        dsp_core_pkg::OP_ROTATE_ACC: {carry, accumulator} <= {accumulator, carry};
        default: accumulator <= accumulator;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      test_flag <= 1'b0;
    end else if (take && op == dsp_core_pkg::OP_BIT_DYN) begin
      test_flag <= data_in[multiplier_operand_register[3:0]];
    end
  end

  // ----------------------------------------
  // data-write bus
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_write_bus <= 16'h0000;
      data_write_valid <= 1'b0;
    end else begin
      data_write_valid <= take && (op == dsp_core_pkg::OP_STORE_ACC || op == dsp_core_pkg::OP_STORE_PROD);
      if (take && op == dsp_core_pkg::OP_STORE_ACC) begin
        data_write_bus <= out_high ? out_scaled[31:16] : out_scaled[15:0];
      end else if (take && op == dsp_core_pkg::OP_STORE_PROD) begin
        data_write_bus <= out_high ? prod_scaled[31:16] : prod_scaled[15:0];
      end
    end
  end

  // ----------------------------------------
  // return stack
  // ----------------------------------------
  logic [15:0] next_address_register;
  logic [15:0] current_address_register;
  logic [15:0] stack_mem [STACK_DEPTH];
  logic [15:0] stack_top;
  logic [15:0] pc_inc;
  logic want_push;
  logic want_pop;
  logic do_push;
  logic do_pop;
  assign pc_inc = next_address_register + 16'h0001;
  assign stack_top = stack_depth == 4'h0 ? 16'h0000 : stack_mem[3'(stack_depth - 4'h1)];
  // address ops are ignored during a block, so they must not touch the stack either
  assign want_push = take && is_push(op) && (op == dsp_core_pkg::OP_PUSH
    || (!block_active && (op != dsp_core_pkg::OP_CALL || cond_true)));
  assign want_pop = take && is_pop(op) && (op == dsp_core_pkg::OP_POP || !block_active);
  assign do_push = want_push && stack_depth < 4'(STACK_DEPTH);
  assign do_pop = want_pop && stack_depth != 4'h0;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stack_depth <= 4'h0;
      stack_error <= 1'b0;
    end else begin
      if (do_push) begin
        stack_mem[3'(stack_depth)] <= op == dsp_core_pkg::OP_PUSH ? accumulator[15:0] : pc_inc;
        stack_depth <= stack_depth + 4'h1;
      end else if (do_pop) begin
        stack_depth <= stack_depth - 4'h1;
      end
      // a ninth push is dropped: the hardware stack has no spill to memory
      if ((want_push && stack_depth == 4'(STACK_DEPTH)) || (want_pop && stack_depth == 4'h0)) begin
        stack_error <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // program address generation
  // ----------------------------------------
  logic [15:0] micro_stack;
  logic [15:0] block_count;
  logic [15:0] next_next_address_register;
  assign program_address_bus = current_address_register;

  always_comb begin
    next_next_address_register = pc_inc;
    if (block_active && block_count == 16'h0000) begin
      next_next_address_register = micro_stack;
    end else if (!block_active && take) begin
      case (op)
        dsp_core_pkg::OP_BRANCH, dsp_core_pkg::OP_CALL: if (cond_true) next_next_address_register = target;
        dsp_core_pkg::OP_RETURN: if (stack_depth != 4'h0) next_next_address_register = stack_top;
        dsp_core_pkg::OP_TRAP: next_next_address_register = `TRAP_BASE + (16'(trap_num) << `TRAP_STRIDE_SHIFT);
        // a zero-length block is a no-op and must not jump
        dsp_core_pkg::OP_BLOCK: if (block_len != 16'h0000) next_next_address_register = target;
        default: next_next_address_register = pc_inc;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      next_address_register <= `ADDR_RST;
      current_address_register <= `ADDR_RST;
    end else if (mem_ready) begin
      current_address_register <= next_address_register;
      next_address_register <= next_next_address_register;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      micro_stack <= `ADDR_RST;
      block_count <= 16'h0000;
      block_active <= 1'b0;
    end else if (mem_ready) begin
      if (block_active) begin
        block_count <= block_count - 16'h0001;
        block_active <= block_count != 16'h0000;
      end else if (take && op == dsp_core_pkg::OP_BLOCK && block_len != 16'h0000) begin
        micro_stack <= pc_inc;
        block_count <= block_len - 16'h0001;
        block_active <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_par_hold_stall: assert property (@(posedge mclk) disable iff (sys_rst)
    !mem_ready |=> $stable(program_address_bus))
    else $error("bus address moved during a wait state");

  chk_par_follows_next_address_register: assert property (@(posedge mclk) disable iff (sys_rst)
    mem_ready |=> program_address_bus == $past(next_address_register))
    else $error("bus address did not take the next address");

  chk_seq_increment: assert property (@(posedge mclk) disable iff (sys_rst)
    mem_ready && !op_valid && !block_active |=> next_address_register == $past(next_address_register) + 16'h0001)
    else $error("sequential fetch did not increment");

  chk_mult_one_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
    take && op == dsp_core_pkg::OP_MULTIPLY && !signed_mode
    |=> product_register == 32'($past(multiplier_operand_register) * $past(data_in)))
    else $error("unsigned product wrong or late");

  chk_prod_held: assert property (@(posedge mclk) disable iff (sys_rst)
    !(take && op == dsp_core_pkg::OP_MULTIPLY) |=> $stable(product_register))
    else $error("product changed without a multiply");

  chk_load_shift: assert property (@(posedge mclk) disable iff (sys_rst)
    take && op == dsp_core_pkg::OP_LOAD_ACC && !sign_ext && shift_amt == 5'h10
    |=> accumulator == {$past(data_in), 16'h0000})
    else $error("sixteen-bit input shift wrong");

  chk_dyn_shift: assert property (@(posedge mclk) disable iff (sys_rst)
    take && op == dsp_core_pkg::OP_LOAD_ACC_DYN && !sign_ext
    |=> accumulator == ({16'h0000, $past(data_in)} << $past(multiplier_operand_register[3:0])))
    else $error("dynamic shift count not taken from operand register");

  chk_prod_right: assert property (@(posedge mclk) disable iff (sys_rst)
    take && op == dsp_core_pkg::OP_LOAD_PROD_ACC && pm_mode == dsp_core_pkg::PM_RIGHT
    |=> accumulator == 32'($signed($past(product_register)) >>> 6))
    else $error("product right shift wrong");

  chk_store_high: assert property (@(posedge mclk) disable iff (sys_rst)
    take && op == dsp_core_pkg::OP_STORE_ACC && out_high
    |=> data_write_valid && data_write_bus == 16'($past(accumulator) << $past(out_shift) >> 16))
    else $error("output scaler high half wrong");

  chk_trap_vector: assert property (@(posedge mclk) disable iff (sys_rst)
    take && op == dsp_core_pkg::OP_TRAP && !block_active
    |=> next_address_register == 16'({$past(trap_num), 1'b0}) && stack_depth == $past(stack_depth) + 4'h1
        || $past(stack_depth) == 4'h8)
    else $error("trap vector or return push wrong");

  chk_stack_bound: assert property (@(posedge mclk) disable iff (sys_rst)
    stack_depth <= 4'(STACK_DEPTH))
    else $error("return stack deeper than eight");

  chk_reset_clear: assert property (@(posedge mclk)
    sys_rst |=> accumulator == 32'h0000_0000 && product_register == 32'h0000_0000
      && multiplier_operand_register == 16'h0000)
    else $error("datapath not cleared by reset");

endmodule // dsp_core_multiply_scale_datapath

// ===== verif/mem_model.sv
// partner model of the on-chip memory handshake: prompt or with wait states
`timescale 1ns/1ps
module mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // wait-state request from the bench
  input wire logic stall_go,
  input wire logic [3:0] stall_len,
  // bus handshake
  output logic mem_ready
);
  logic [3:0] cnt;
  // ----------------------------------------
  // wait states, changed only after an edge
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt <= 4'h0;
      mem_ready <= 1'b1;
    end else if (stall_go) begin
      cnt <= stall_len;
      mem_ready <= 1'b0;
    end else if (cnt > 4'h1) begin
      cnt <= cnt - 4'h1;
    end else begin
      cnt <= 4'h0;
      mem_ready <= 1'b1;
    end
  end
endmodule // mem_model

// ===== verif/dsp_core_multiply_scale_datapath_test.sv
// self-checking bench for the multiply, scale and program-address datapath
`timescale 1ns/1ps
module dsp_core_multiply_scale_datapath_test;
  logic mclk, sys_rst, op_valid, signed_mode, sign_ext, out_high, mem_ready, stall_go;
  dsp_core_pkg::op_t op;
  dsp_core_pkg::pm_t pm_mode;
  dsp_core_pkg::cond_t cond;
  logic [4:0] shift_amt, trap_num;
  logic [2:0] out_shift;
  logic [3:0] stall_len, stack_depth;
  logic [15:0] target, block_len, data_in, data_write_bus, program_address_bus, multiplier_operand_register;
  logic [31:0] accumulator, product_register;
  logic data_write_valid, test_flag, carry, stack_error, block_active;
  int err_total, n_checks, cycles;
  logic [15:0] p;

  mem_model u_mem_model (.mclk(mclk), .sys_rst(sys_rst), .stall_go(stall_go), .stall_len(stall_len),
    .mem_ready(mem_ready));
  dsp_core_multiply_scale_datapath u_dsp_core_multiply_scale_datapath (.mclk(mclk), .sys_rst(sys_rst),
    .op_valid(op_valid), .op(op), .signed_mode(signed_mode), .sign_ext(sign_ext), .shift_amt(shift_amt),
    .pm_mode(pm_mode), .out_shift(out_shift), .out_high(out_high), .cond(cond), .target(target),
    .trap_num(trap_num), .block_len(block_len), .data_in(data_in), .data_write_bus(data_write_bus),
    .data_write_valid(data_write_valid), .mem_ready(mem_ready), .program_address_bus(program_address_bus),
    .accumulator(accumulator), .product_register(product_register),
    .multiplier_operand_register(multiplier_operand_register), .test_flag(test_flag), .carry(carry),
    .stack_depth(stack_depth), .stack_error(stack_error), .block_active(block_active));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // op set after an edge is taken at the next edge
  task automatic drive(input dsp_core_pkg::op_t o, input logic [15:0] d);
    @(posedge mclk);
    op_valid <= 1'b1;
    op <= o;
    data_in <= d;
  endtask
  // last op taken here; returns at the negedge where results have settled
  task automatic stop();
    @(posedge mclk);
    op_valid <= 1'b0;
    @(negedge mclk);
  endtask
  // branch taken at the stop edge; p holds the bus address seen half a cycle before it
  task automatic jump(input dsp_core_pkg::cond_t c, input logic [15:0] t);
    drive(dsp_core_pkg::OP_BRANCH, 16'h0000);
    cond <= c;
    target <= t;
    @(negedge mclk);
    p = program_address_bus;
    stop();
    @(negedge mclk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_mul();
    drive(dsp_core_pkg::OP_LOAD_OPND, 16'hFFFF);
    drive(dsp_core_pkg::OP_MULTIPLY, 16'h0002);
    signed_mode <= 1'b1;
    drive(dsp_core_pkg::OP_MULTIPLY, 16'h0002);
    signed_mode <= 1'b0;
    @(negedge mclk);
    check(product_register, 32'hFFFF_FFFE);
    stop();
    check(product_register, 32'h0001_FFFE);
    drive(dsp_core_pkg::OP_LOAD_ACC, 16'h0000);
    stop();
    check(product_register, 32'h0001_FFFE);
  endtask
  task automatic t_product_scaler();
    logic [31:0] exp [4];
    exp = '{32'h0040_0000, 32'h0080_0000, 32'h0400_0000, 32'h0001_0000};
    drive(dsp_core_pkg::OP_LOAD_OPND, 16'h4000);
    drive(dsp_core_pkg::OP_MULTIPLY, 16'h0100);
    for (int i = 0; i < 4; i++) begin
      drive(dsp_core_pkg::OP_LOAD_PROD_ACC, 16'h0000);
      pm_mode <= dsp_core_pkg::pm_t'(i);
      stop();
      check(accumulator, exp[i]);
    end
    @(posedge mclk);
    pm_mode <= dsp_core_pkg::PM_NONE;
  endtask
  task automatic t_input_scaler();
    logic [4:0] sh [5];
    logic [31:0] exp [5];
    sh = '{5'h00, 5'h01, 5'h10, 5'h14, 5'h01};
    exp = '{32'h0000_8001, 32'h0001_0002, 32'h8001_0000, 32'h8001_0000, 32'hFFFF_0002};
    for (int i = 0; i < 5; i++) begin
      drive(dsp_core_pkg::OP_LOAD_ACC, 16'h8001);
      shift_amt <= sh[i];
      sign_ext <= (i == 4);
      stop();
      check(accumulator, exp[i]);
    end
    drive(dsp_core_pkg::OP_LOAD_OPND, 16'h0004);
    sign_ext <= 1'b0;
    drive(dsp_core_pkg::OP_LOAD_ACC_DYN, 16'h0003);
    shift_amt <= 5'h00;
    stop();
    check(accumulator, 32'h0000_0030);
  endtask
  task automatic t_bit();
    drive(dsp_core_pkg::OP_LOAD_OPND, 16'h0003);
    drive(dsp_core_pkg::OP_BIT_DYN, 16'h0008);
    stop();
    check(test_flag, 32'h1);
    drive(dsp_core_pkg::OP_BIT_DYN, 16'hFFF7);
    stop();
    check(test_flag, 32'h0);
  endtask
  task automatic t_output_scaler();
    drive(dsp_core_pkg::OP_LOAD_ACC, 16'h1234);
    shift_amt <= 5'h10;
    drive(dsp_core_pkg::OP_ADD, 16'h5678);
    shift_amt <= 5'h00;
    drive(dsp_core_pkg::OP_STORE_ACC, 16'h0000);
    out_shift <= 3'h4;
    out_high <= 1'b1;
    drive(dsp_core_pkg::OP_STORE_ACC, 16'h0000);
    out_high <= 1'b0;
    @(negedge mclk);
    check({data_write_valid, data_write_bus}, 32'h1_2345);
    stop();
    check({data_write_valid, data_write_bus}, 32'h1_6780);
    @(negedge mclk);
    check(data_write_valid, 32'h0);
  endtask
  task automatic t_addr();
    @(posedge mclk);
    stall_go <= 1'b1;
    stall_len <= 4'h3;
    @(posedge mclk);
    stall_go <= 1'b0;
    @(negedge mclk);
    p = program_address_bus;
    repeat (3) begin
      @(negedge mclk);
      check(program_address_bus, p);
    end
    @(negedge mclk);
    check(program_address_bus, p + 16'h1);
    @(negedge mclk);
    check(program_address_bus, p + 16'h2);
  endtask
  task automatic t_flow();
    drive(dsp_core_pkg::OP_BRANCH, 16'h0000);
    cond <= dsp_core_pkg::COND_ALWAYS;
    target <= 16'h0200;
    stop();
    @(negedge mclk);
    check(program_address_bus, 16'h0200);
    drive(dsp_core_pkg::OP_BRANCH, 16'h0000);
    cond <= dsp_core_pkg::COND_EQ;
    target <= 16'h0300;
    stop();
    @(negedge mclk);
    check(program_address_bus[15:8], 8'h02);
    drive(dsp_core_pkg::OP_CALL, 16'h0000);
    cond <= dsp_core_pkg::COND_ALWAYS;
    target <= 16'h0400;
    @(negedge mclk);
    p = program_address_bus;
    stop();
    @(negedge mclk);
    check({stack_depth, program_address_bus}, {4'h1, 16'h0400});
    drive(dsp_core_pkg::OP_RETURN, 16'h0000);
    stop();
    @(negedge mclk);
    check({stack_depth, program_address_bus}, {4'h0, p + 16'h2});
    drive(dsp_core_pkg::OP_TRAP, 16'h0000);
    trap_num <= 5'h1F;
    stop();
    @(negedge mclk);
    check({stack_depth, program_address_bus}, {4'h1, 16'h003E});
    drive(dsp_core_pkg::OP_RETURN, 16'h0000);
    stop();
  endtask
  task automatic t_stack();
    repeat (9) drive(dsp_core_pkg::OP_PUSH, 16'h0000);
    stop();
    check({stack_error, stack_depth}, {1'b1, 4'h8});
    repeat (8) drive(dsp_core_pkg::OP_POP, 16'h0000);
    stop();
    check(stack_depth, 32'h0);
  endtask
  task automatic t_block();
    logic [15:0] exp [3];
    exp = '{16'h0100, 16'h0101, 16'h0102};
    drive(dsp_core_pkg::OP_BLOCK, 16'h0000);
    target <= 16'h0100;
    block_len <= 16'h0003;
    @(negedge mclk);
    p = program_address_bus;
    stop();
    check(block_active, 32'h1);
    for (int i = 0; i < 3; i++) begin
      @(negedge mclk);
      check(program_address_bus, exp[i]);
    end
    check(block_active, 32'h0);
    @(negedge mclk);
    check(program_address_bus, p + 16'h2);
  endtask
  // runs after t_bit and t_product_scaler: operand register is 3, product register 0x0040_0000
  task automatic t_alu();
    drive(dsp_core_pkg::OP_LOAD_ACC, 16'h0005);
    drive(dsp_core_pkg::OP_SUB, 16'h0007);
    stop();
    check(accumulator, 32'hFFFF_FFFE);
    check(carry, 32'h0);
    jump(dsp_core_pkg::COND_C, 16'h0600);
    check(program_address_bus, p + 16'h2);
    jump(dsp_core_pkg::COND_GT, 16'h0800);
    check(program_address_bus, p + 16'h2);
    jump(dsp_core_pkg::COND_LT, 16'h0500);
    check(program_address_bus, 16'h0500);
    jump(dsp_core_pkg::COND_NE, 16'h0900);
    check(program_address_bus, 16'h0900);
    drive(dsp_core_pkg::OP_BIT_DYN, 16'h0008);
    stop();
    jump(dsp_core_pkg::COND_TC, 16'h0700);
    check(program_address_bus, 16'h0700);
    drive(dsp_core_pkg::OP_ADD_PROD, 16'h0000);
    stop();
    check(accumulator, 32'h003F_FFFE);
    jump(dsp_core_pkg::COND_C, 16'h0A00);
    check(program_address_bus, 16'h0A00);
    drive(dsp_core_pkg::OP_SUB_PROD, 16'h0000);
    drive(dsp_core_pkg::OP_SHIFT_ACC, 16'h0000);
    drive(dsp_core_pkg::OP_ROTATE_ACC, 16'h0000);
    stop();
    check(accumulator, 32'hFFFF_FFF9);
    check(carry, 32'h1);
    drive(dsp_core_pkg::OP_STORE_PROD, 16'h0000);
    pm_mode <= dsp_core_pkg::PM_LEFT_B;
    out_high <= 1'b1;
    drive(dsp_core_pkg::OP_ADD_DYN, 16'h0001);
    pm_mode <= dsp_core_pkg::PM_NONE;
    out_high <= 1'b0;
    @(negedge mclk);
    check({data_write_valid, data_write_bus}, 32'h1_0400);
    stop();
    check(accumulator, 32'h0000_0001);
    check(carry, 32'h1);
  endtask

  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    sys_rst = 1'b1;
    op_valid = 1'b0;
    op = dsp_core_pkg::OP_NOP;
    signed_mode = 1'b0;
    sign_ext = 1'b0;
    shift_amt = 5'h00;
    pm_mode = dsp_core_pkg::PM_NONE;
    out_shift = 3'h0;
    out_high = 1'b0;
    cond = dsp_core_pkg::COND_ALWAYS;
    target = 16'h0000;
    trap_num = 5'h00;
    block_len = 16'h0000;
    data_in = 16'h0000;
    stall_go = 1'b0;
    stall_len = 4'h0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    check(accumulator, 32'h0);
    check(product_register, 32'h0);
    check(multiplier_operand_register, 32'h0);
    check({data_write_valid, carry, program_address_bus}, 32'h1_0000);
    t_mul();
    t_product_scaler();
    t_input_scaler();
    t_bit();
    t_output_scaler();
    t_addr();
    t_flow();
    t_stack();
    t_block();
    t_alu();
    wrap_up();
  end
endmodule // dsp_core_multiply_scale_datapath_test
